// ==== rtl/sys_decode_defs.vh ====
// Address map, target indices, sizes and states of the system decoder
`ifndef SYS_DECODE_DEFS_VH
`define SYS_DECODE_DEFS_VH

`define FLASH_FIRST 32'h0000_0000
`define FLASH_LAST 32'h0001_FFFF
`define SRAM_FIRST 32'h2000_0000
`define SRAM_LAST 32'h2000_7FFF
`define SRAM_ALIAS_FIRST 32'h2200_0000
`define SRAM_ALIAS_LAST 32'h220F_FFFF
`define PERI_BAND_FIRST 32'h4000_0000
`define PERI_ALIAS_FIRST 32'h4200_0000
`define PERI_ALIAS_LAST 32'h43FF_FFFF
`define WDT_FIRST 32'h4000_0000
`define WDT_LAST 32'h4000_0FFF
`define GPIO_FIRST 32'h4000_4000
`define SLOT_SIZE 32'h0000_1000
`define SLOT_LAST_OFF 32'h0000_0FFF
`define CORE_FIRST 32'hE000_0000
`define CORE_LAST 32'hE00F_FFFF

// Alias word address to target byte address: divide offset by 32
`define BB_SHIFT 5
`define GPIO_PORTS 4

// One-hot target positions
`define TGT_COUNT 8
`define TGT_FLASH 0
`define TGT_SRAM 1
`define TGT_WDT 2
`define TGT_GPIOA 3
`define TGT_CORE 7

// Transfer size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

`define BE_NONE 4'h0
`define BE_BYTE 4'h1
`define BE_HALF 4'h3
`define BE_WORD 4'hF

// Sequencer states
`define ST_IDLE 2'h0
`define ST_ACC 2'h1
`define ST_WB 2'h2

`endif

// ==== rtl/addr_range_match.v ====
// Inclusive address range comparator
`timescale 1ns/1ns
`default_nettype none
module addr_range_match #(
	parameter [31:0] FIRST = 32'h0000_0000,
	parameter [31:0] LAST = 32'h0000_0000
) (
	input wire [31:0] addr,
	output wire hit
);
	assign hit = (addr >= FIRST) && (addr <= LAST);
endmodule // addr_range_match
`default_nettype wire

// ==== rtl/sys_decoder.v ====
// System address decoder: fixed map, bit-band alias, bus-fault on holes
`timescale 1ns/1ns
`default_nettype none
`include "sys_decode_defs.vh"
module sys_decoder (
	input wire clk,
	input wire rst_n,
	input wire req_valid,
	input wire req_write,
	input wire [1:0] req_size,
	input wire [31:0] req_addr,
	input wire [31:0] req_wdata,
	output reg req_ready,
	output reg resp_valid,
	output reg resp_fault,
	output reg [31:0] resp_rdata,
	output reg [7:0] tgt_sel,
	output reg tgt_write,
	output reg [3:0] tgt_be,
	output reg [31:0] tgt_addr,
	output reg [31:0] tgt_wdata,
	output reg tgt_lock,
	input wire [7:0] tgt_ready,
	input wire [255:0] tgt_rdata
);
	wire hit_sram_alias;
	wire hit_peri_alias;
	wire [7:0] hit;
	reg [31:0] eff;
	reg is_alias;
	reg misalign;
	reg [3:0] be;
	reg [31:0] base;
	reg [31:0] lane_rdata;
	reg [1:0] state;
	reg [7:0] cur_sel;
	reg cur_alias;
	reg cur_awrite;
	reg [4:0] cur_bit;
	reg cur_wbit;
	wire fault;
	wire [4:0] bit_pos;
	wire sel_ready;
	wire [31:0] wb_data;
	integer i;

	// Alias windows are matched on the raw address
	addr_range_match #(.FIRST(`SRAM_ALIAS_FIRST), .LAST(`SRAM_ALIAS_LAST))
	u_sram_alias (.addr(req_addr), .hit(hit_sram_alias));
	addr_range_match #(.FIRST(`PERI_ALIAS_FIRST), .LAST(`PERI_ALIAS_LAST))
	u_peri_alias (.addr(req_addr), .hit(hit_peri_alias));

	// Alias offset / 32 gives the target byte address
	always @* begin
		is_alias = hit_sram_alias | hit_peri_alias;
		if (hit_sram_alias) begin
			eff = `SRAM_FIRST +
				((req_addr - `SRAM_ALIAS_FIRST) >> `BB_SHIFT);
		end else if (hit_peri_alias) begin
			eff = `PERI_BAND_FIRST +
				((req_addr - `PERI_ALIAS_FIRST) >> `BB_SHIFT);
		end else begin
			eff = req_addr;
		end
	end

	// Targets are matched on the effective address
	addr_range_match #(.FIRST(`FLASH_FIRST), .LAST(`FLASH_LAST))
	u_flash (.addr(eff), .hit(hit[`TGT_FLASH]));
	addr_range_match #(.FIRST(`SRAM_FIRST), .LAST(`SRAM_LAST))
	u_sram (.addr(eff), .hit(hit[`TGT_SRAM]));
	addr_range_match #(.FIRST(`WDT_FIRST), .LAST(`WDT_LAST))
	u_wdt (.addr(eff), .hit(hit[`TGT_WDT]));
	genvar g;
	generate
		for (g = 0; g < `GPIO_PORTS; g = g + 1) begin : gpio_slot
			addr_range_match #(
				.FIRST(`GPIO_FIRST + g * `SLOT_SIZE),
				.LAST(`GPIO_FIRST + g * `SLOT_SIZE + `SLOT_LAST_OFF)
			) u_gpio (.addr(eff), .hit(hit[`TGT_GPIOA + g]));
		end
	endgenerate
	// The core bus is not a bit-band target, so raw address is used
	addr_range_match #(.FIRST(`CORE_FIRST), .LAST(`CORE_LAST))
	u_core (.addr(req_addr), .hit(hit[`TGT_CORE]));

	// Bit number inside the word, little-endian byte order
	assign bit_pos = {eff[1:0], req_addr[4:2]};

	always @* begin
		misalign = 1'b0;
		be = `BE_NONE;
		case (req_size)
		`SIZE_BYTE: begin
			be = `BE_BYTE << req_addr[1:0];
		end
		`SIZE_HALF: begin
			misalign = req_addr[0];
			be = `BE_HALF << {req_addr[1], 1'b0};
		end
		`SIZE_WORD: begin
			misalign = |req_addr[1:0];
			be = `BE_WORD;
		end
		default: begin
			misalign = 1'b1;
		end
		endcase
		if (is_alias) begin
			misalign = 1'b0;
			be = `BE_WORD;
		end
	end

	always @* begin
		case (hit)
		8'h01: base = `FLASH_FIRST;
		8'h02: base = `SRAM_FIRST;
		8'h04: base = `WDT_FIRST;
		8'h08: base = `GPIO_FIRST;
		8'h10: base = `GPIO_FIRST + `SLOT_SIZE;
		8'h20: base = `GPIO_FIRST + 2 * `SLOT_SIZE;
		8'h40: base = `GPIO_FIRST + 3 * `SLOT_SIZE;
		8'h80: base = `CORE_FIRST;
		default: base = `FLASH_FIRST;
		endcase
	end

	assign fault = ~|hit | misalign;

	// Read data and ready of the one selected target
	always @* begin
		lane_rdata = 32'h0000_0000;
		for (i = 0; i < `TGT_COUNT; i = i + 1) begin
			if (cur_sel[i]) begin
				lane_rdata = lane_rdata | tgt_rdata[i * 32 +: 32];
			end
		end
	end
	assign sel_ready = |(tgt_ready & tgt_sel);

	assign wb_data = (lane_rdata & ~(32'h0000_0001 << cur_bit)) |
		({31'h0000_0000, cur_wbit} << cur_bit);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= `ST_IDLE;
			req_ready <= 1'b1;
			resp_valid <= 1'b0;
			resp_fault <= 1'b0;
			resp_rdata <= 32'h0000_0000;
			tgt_sel <= 8'h00;
			tgt_write <= 1'b0;
			tgt_be <= `BE_NONE;
			tgt_addr <= 32'h0000_0000;
			tgt_wdata <= 32'h0000_0000;
			tgt_lock <= 1'b0;
			cur_sel <= 8'h00;
			cur_alias <= 1'b0;
			cur_awrite <= 1'b0;
			cur_bit <= 5'h00;
			cur_wbit <= 1'b0;
		end else begin
			resp_valid <= 1'b0;
			case (state)
			`ST_IDLE: begin
				if (req_valid && req_ready) begin
					if (fault) begin
						resp_valid <= 1'b1;
						resp_fault <= 1'b1;
						resp_rdata <= 32'h0000_0000;
					end else begin
						req_ready <= 1'b0;
						tgt_sel <= hit;
						cur_sel <= hit;
						tgt_addr <= eff - base;
						tgt_be <= be;
						tgt_write <= req_write & ~is_alias;
						tgt_wdata <= req_wdata;
						tgt_lock <= is_alias & req_write;
						cur_alias <= is_alias;
						cur_awrite <= is_alias & req_write;
						cur_bit <= bit_pos;
						cur_wbit <= req_wdata[0];
						state <= `ST_ACC;
					end
				end
			end
			`ST_ACC: begin
				if (sel_ready) begin
					tgt_sel <= 8'h00;
					if (cur_awrite && !tgt_write) begin
						tgt_wdata <= wb_data;
						tgt_write <= 1'b1;
						state <= `ST_WB;
					end else begin
						resp_valid <= 1'b1;
						resp_fault <= 1'b0;
						if (cur_alias) begin
							resp_rdata <= cur_awrite ? 32'h0000_0000 :
								{31'h0000_0000, lane_rdata[cur_bit]};
						end else begin
							resp_rdata <= lane_rdata;
						end
						tgt_lock <= 1'b0;
						tgt_write <= 1'b0;
						req_ready <= 1'b1;
						state <= `ST_IDLE;
					end
				end
			end
			`ST_WB: begin
				tgt_sel <= cur_sel;
				state <= `ST_ACC;
			end
			default: begin
				state <= `ST_IDLE;
				req_ready <= 1'b1;
				tgt_sel <= 8'h00;
				tgt_lock <= 1'b0;
			end
			endcase
		end
	end
endmodule // sys_decoder
`default_nettype wire

// ==== verification/sys_decoder_sva.sv ====
// Port checker for the system decoder
`timescale 1ns/1ns
`default_nettype none
module sys_decoder_sva (
	input wire clk,
	input wire rst_n,
	input wire req_valid,
	input wire req_ready,
	input wire [1:0] req_size,
	input wire [31:0] req_addr,
	input wire resp_valid,
	input wire resp_fault,
	input wire [7:0] tgt_sel,
	input wire [3:0] tgt_be,
	input wire [31:0] tgt_addr,
	input wire tgt_lock
);
	wire tk = req_valid && req_ready && req_size == 2'h0;
	wire [31:0] a = req_addr;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	one_sel_a: assert property ($onehot0(tgt_sel))
		else $error("select not one-hot");
	hole_fault_a: assert property (tk && a[31:29] == 3'h0
		&& a[28:17] != 12'h000
		|=> resp_valid && resp_fault && tgt_sel == 8'h00)
		else $error("no fault");
	flash_sel_a: assert property (tk && a[31:17] == 15'h0000
		|=> tgt_sel == 8'h01) else $error("flash select");
	sram_sel_a: assert property (tk && a[31:15] == 17'h4000
		|=> tgt_sel == 8'h02 && tgt_addr == $past(a) - 32'h2000_0000)
		else $error("sram select");
	alias_map_a: assert property (tk && a[31:20] == 12'h220
		|=> tgt_sel == 8'h02 && tgt_addr == $past(a[19:5]))
		else $error("alias map");
	wdt_sel_a: assert property (tk && a[31:12] == 20'h4_0000
		|=> tgt_sel == 8'h04) else $error("watchdog select");
	gpio_sel_a: assert property (tk && a[31:14] == 18'h1_0001
		|=> tgt_sel == 8'h08 << $past(a[13:12])) else $error("port select");
	half_lane_a: assert property (req_valid && req_ready
		&& req_size == 2'h1 && a[31:15] == 17'h4000 && !a[0]
		|=> tgt_be == 4'h3 << 2 * $past(a[1]))
		else $error("halfword lanes");
	lock_hold_a: assert property ($rose(tgt_lock) |-> tgt_lock [*3])
		else $error("lock dropped");
	cover property (resp_valid && resp_fault);
	cover property ($rose(tgt_lock));
	cover property (tgt_sel[6]);
endmodule // sys_decoder_sva
bind sys_decoder sys_decoder_sva chk_i (.clk, .rst_n, .req_valid, .req_ready,
	.req_size, .req_addr, .resp_valid, .resp_fault, .tgt_sel, .tgt_be,
	.tgt_addr, .tgt_lock);
`default_nettype wire

// ==== verification/tgt_model.sv ====
// Memory-like model of the eight decoder targets
`timescale 1ns/1ns
`default_nettype none
module tgt_model (
	input wire clk,
	input wire [7:0] tgt_sel,
	input wire tgt_write,
	input wire [3:0] tgt_be,
	input wire [31:0] tgt_addr,
	input wire [31:0] tgt_wdata,
	output logic [7:0] tgt_ready = 0,
	output logic [255:0] tgt_rdata = 0
);
	logic [31:0] mem [8][16] = '{default: 0};
	logic slow = 0;
	int i, b;
	always @(posedge clk) begin
		slow <= ~slow;
		for (i = 0; i < 8; i++) begin
			// Answer at once or one cycle late; idle data keeps changing
			tgt_ready[i] <= tgt_sel[i] && !tgt_ready[i] && !slow;
			tgt_rdata[32*i+:32] <= ~tgt_rdata[32*i+:32];
			if (tgt_sel[i] && !tgt_ready[i])
				tgt_rdata[32*i+:32] <= mem[i][tgt_addr[5:2]];
			for (b = 0; b < 4; b++)
				if (tgt_sel[i] && tgt_ready[i] && tgt_write && tgt_be[b])
					mem[i][tgt_addr[5:2]][8*b+:8] <= tgt_wdata[8*b+:8];
		end
	end
endmodule // tgt_model
`default_nettype wire

// ==== verification/testbench.sv ====
// Random and corner-case bench for the system decoder
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 0, rst_n = 0, req_valid = 0, req_write = 0;
	logic [1:0] req_size = 0;
	logic [31:0] req_addr = 0, req_wdata = 0, rd;
	wire req_ready, resp_valid, resp_fault, tgt_write, tgt_lock;
	wire [31:0] resp_rdata, tgt_addr, tgt_wdata;
	wire [7:0] tgt_sel, tgt_ready;
	wire [3:0] tgt_be;
	wire [255:0] tgt_rdata;
	int n_fail = 0, n_checks = 0, seed = 32'hc69f, i;
	logic [31:0] cor [16] = '{32'h1_FFFF, 32'h2_0000, 32'h2000_7FFF,
		32'h2000_8000, 32'h220F_FFFF, 32'h2210_0000, 32'h4000_0FFF,
		32'h4000_1000, 32'h4000_3FFF, 32'h4000_7FFF, 32'h4000_8000,
		32'h4200_0000, 32'h4400_0000, 32'hE00F_FFFF, 32'hE010_0000, '1};
	logic [31:0] bases [8] = '{0, 32'h2000_0000, 32'h2200_0000, 32'h4000_0000,
		32'h4000_4000, 32'h4200_0000, 32'hE000_0000, 32'h4000_8000};
	always #10 clk = ~clk;
	sys_decoder dut (.clk, .rst_n, .req_valid, .req_write, .req_size,
		.req_addr, .req_wdata, .req_ready, .resp_valid, .resp_fault,
		.resp_rdata, .tgt_sel, .tgt_write, .tgt_be, .tgt_addr, .tgt_wdata,
		.tgt_lock, .tgt_ready, .tgt_rdata);
	tgt_model tgt (.clk, .tgt_sel, .tgt_write, .tgt_be, .tgt_addr,
		.tgt_wdata, .tgt_ready, .tgt_rdata);
	// Expected select and target offset; zero select means bus fault
	function automatic logic [39:0] dec(logic [31:0] a, logic [1:0] s);
		logic bad = s == 3 || (s == 1 && a[0]) || (s == 2 && a[1:0] != 0);
		if (a[31:20] == 12'h220) return {8'h02, 17'h0, a[19:5]};
		if (a[31:25] == 7'h21) return dec(32'h4000_0000 + a[24:5], 0);
		if (bad) return 0;
		if (a < 32'h2_0000) return {8'h01, a};
		if (a[31:15] == 17'h4000) return {8'h02, 17'h0, a[14:0]};
		if (a[31:12] == 20'h40000) return {8'h04, 20'h0, a[11:0]};
		if (a[31:14] == 18'h10001) return {8'h08 << a[13:12], 20'h0, a[11:0]};
		if (a[31:20] == 12'hE00) return {8'h80, 12'h0, a[19:0]};
		return 0;
	endfunction
	task chk(input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task end_sim;
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task acc(input logic w, input logic [1:0] s, input logic [31:0] a, d);
		logic [39:0] e;
		logic [7:0] sl;
		logic [31:0] ta;
		logic [3:0] tb, eb;
		int n;
		e = dec(a, s);
		sl = 0;
		eb = s == 0 ? 4'h1 << a[1:0] : s == 1 ? 4'h3 << {a[1], 1'b0} : 4'hF;
		if (a[31:20] == 12'h220 || a[31:25] == 7'h21) eb = 4'hF;
		// Requests are launched on a clock edge
		@(posedge clk);
		req_valid <= 1;
		req_write <= w;
		req_size <= s;
		req_addr <= a;
		req_wdata <= d;
		@(posedge clk);
		req_valid <= 0;
		for (n = 0; n < 60; n++) begin
			#1;
			if (resp_valid === 1'b1) break;
			if (sl === 8'h00 && tgt_sel !== 8'h00) begin
				sl = tgt_sel;
				ta = tgt_addr;
				tb = tgt_be;
			end
			@(posedge clk);
		end
		if (n == 60) begin
			n_fail++;
			end_sim;
		end
		chk(sl, e[39:32]);
		chk(resp_fault, e[39:32] == 0);
		if (sl !== 0) chk(ta, e[31:0]);
		if (sl !== 0) chk(tb, eb);
		rd = resp_rdata;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		#1 chk({req_ready, tgt_sel}, 9'h100);
		acc(1, 2, 32'h2000_0010, 32'h1234_5678);
		acc(1, 0, 32'h2000_0012, 32'h00A5_0000);
		acc(0, 2, 32'h2000_0010, 0);
		chk(rd, 32'h12A5_5678);
		acc(1, 2, 32'h2200_021C, 1);
		chk(rd, 32'h0000_0000);
		acc(0, 2, 32'h2000_0010, 0);
		chk(rd, 32'h12A5_56F8);
		acc(0, 2, 32'h2200_0218, 0);
		chk(rd, 1);
		acc(1, 1, 32'h2000_0016, 32'hBEEF_0000);
		acc(0, 2, 32'h2000_0014, 0);
		chk(rd, 32'hBEEF_0000);
		$display("bit-band test done");
		foreach (cor[i]) acc(0, 0, cor[i], 0);
		$display("boundary test done");
		for (i = 0; i < 80; i++)
			acc($random(seed), $random(seed), bases[$random(seed) & 7]
				+ ($random(seed) & 32'h0000_7FFF), $random(seed));
		$display("random test done");
		end_sim;
	end
endmodule // testbench
`default_nettype wire
